// ---- sim/test_timer_prescale_counter_core.sv ----
// Self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none
module test_timer_prescale_counter_core;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [4:0] awa = 5'h00, ara = 5'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic fclk = 1'b0, eclk = 1'b0, dbg = 1'b0;
   logic awr, wr, bv, arr, rv, irq, cen, dn, sd;
   logic [1:0] bres, rres, r;
   logic [31:0] rdat;
   logic [15:0] cv, mx, aft, pv;
   logic [7:0] d;
   int cyc = 0, bad_count = 0, checks = 0, t0, ex;
   tpcc_core dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(brdy),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv),
      .s_axi_rready(rrdy), .fixed_system_clock(fclk),
      .external_count_clock(eclk), .debug_active(dbg),
      .overflow_irq(irq), .counter_value(cv),
      .center_align_select(cen), .count_down(dn));
   // ---
   // Clock and slow count sources
   // ---
   initial forever #10 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      fclk <= cyc[2];
      eclk <= (cyc % 10) < 5;
   end
   // ---
   // Tasks
   // ---
   task automatic chk(input logic [47:0] g, e, input int tol = 0);
      checks++;
      if ($isunknown(g) || g + tol < e || g > e + tol)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
      @(posedge aclk);
      awa <= a;
      wd <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end
      while (bv !== 1'b1);
      r = bres;
      brdy <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [4:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end
      while (rv !== 1'b1);
      d = rdat[7:0];
      r = rres;
      rrdy <= 1'b0;
   endtask : rd_reg
   // Clear counter, run a fixed span, compare steps
   task automatic measure(input logic [4:0] sc, input int div);
      wr_reg(5'h04, 8'h00);
      wr_reg(5'h00, {3'b000, sc});
      t0 = cyc;
      repeat (400) @(posedge aclk);
      wr_reg(5'h00, 8'h00);
      ex = div == 0 ? 0 : ((cyc - t0) / div) >> sc[2:0];
      repeat (4) @(posedge aclk);
      chk(cv, 16'(ex), 2);
   endtask : measure
   task automatic clear_flag();
      wr_reg(5'h00, 8'h00);
      rd_reg(5'h00);
      wr_reg(5'h00, 8'h00);
   endtask : clear_flag
   // Track peak, value after the top and direction
   task automatic watch();
      mx = 16'h0;
      aft = 16'hffff;
      sd = 1'b0;
      pv = 16'h0;
      repeat (40)
      begin
         @(posedge aclk);
         if (cv > mx) mx = cv;
         if (pv === 16'h3 && cv !== 16'h3) aft = cv;
         sd = sd | dn;
         pv = cv;
      end
   endtask : watch
   task automatic end_of_test();
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // ---
   // Main sequence
   // ---
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         rd_reg(5'(4 * i));
         chk(d, 8'h00);
      end
      rd_reg(5'h14);
      chk(r, tpcc_pkg::AXI_SLVERR);
      wr_reg(5'h14, 8'h00);
      chk(r, tpcc_pkg::AXI_SLVERR);
      for (int p = 0; p < 8; p++)
         measure(5'h08 | 5'(p), 1);
      measure(5'h00, 0);
      measure(5'h11, 8);
      measure(5'h18, 10);
      wr_reg(5'h08, 8'h00);
      wr_reg(5'h0c, 8'h00);
      wr_reg(5'h10, 8'h03);
      wr_reg(5'h00, 8'h08);
      repeat (10) @(posedge aclk);
      rd_reg(5'h00);
      chk(d, 8'h88);
      wr_reg(5'h00, 8'h40);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b1);
      wr_reg(5'h00, 8'h00);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      rd_reg(5'h00);
      chk(d, 8'h80);
      wr_reg(5'h00, 8'h00);
      rd_reg(5'h00);
      chk(d, 8'h00);
      wr_reg(5'h00, 8'h08);
      watch();
      chk({mx, aft, 15'h0, sd}, {16'h3, 16'h0, 16'h0});
      clear_flag();
      wr_reg(5'h00, 8'h28);
      watch();
      chk({aft, 15'h0, sd & cen}, {16'h2, 16'h1});
      rd_reg(5'h00);
      chk(d, 8'ha8);
      clear_flag();
      wr_reg(5'h0c, 8'h00);
      wr_reg(5'h00, 8'h08);
      repeat (20) @(posedge aclk);
      rd_reg(5'h00);
      chk(d, 8'h08);
      wr_reg(5'h10, 8'h03);
      repeat (20) @(posedge aclk);
      rd_reg(5'h00);
      chk(d, 8'h88);
      dbg <= 1'b1;
      repeat (8) @(posedge aclk);
      pv = cv;
      repeat (21) @(posedge aclk);
      chk(cv, pv);
      dbg <= 1'b0;
      wr_reg(5'h10, 8'h00);
      wr_reg(5'h0c, 8'h00);
      wr_reg(5'h08, 8'h5a);
      repeat (200) @(posedge aclk);
      rd_reg(5'h08);
      repeat (300) @(posedge aclk);
      rd_reg(5'h04);
      chk(d, 8'h00);
      rd_reg(5'h08);
      wr_reg(5'h00, 8'h08);
      repeat (300) @(posedge aclk);
      rd_reg(5'h04);
      chk(d > 8'h02, 1'b1);
      wr_reg(5'h00, 8'h00);
      wr_reg(5'h08, 8'h5a);
      repeat (3) @(posedge aclk);
      chk(cv, 16'h0);
      wr_reg(5'h00, 8'h68);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(5'h00);
      chk({d, 7'h0, cen}, 16'h0);
      end_of_test();
   end
   // Hang guard
   initial
   begin
      repeat (30000) @(posedge aclk);
      bad_count++;
      end_of_test();
   end
endmodule : test_timer_prescale_counter_core
`default_nettype wire

// ---- sim/tpcc_core_properties.sv ----
// Port-level assertions for the timer core
`timescale 1ns/1ps
`default_nettype none
module tpcc_core_properties
#(
   parameter int WIDTH = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic debug_active,
   input wire logic overflow_irq,
   input wire logic [WIDTH-1:0] counter_value,
   input wire logic center_align_select
);
   // ---
   // Sequences
   // ---
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Counter byte write taken
   sequence s_cnt_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0]
         && (s_axi_awaddr == 5'h04 || s_axi_awaddr == 5'h08);
   endsequence
   // Debug held past the synchroniser
   sequence s_frozen;
      debug_active [*6];
   endsequence
   // ---
   // Assertions
   // ---
   a_reset_clears:
      assert property (disable iff (1'b0) !aresetn ##1 !aresetn |=>
         !overflow_irq && counter_value == 0 && !center_align_select)
      else $error("outputs not cleared by reset");
   a_count_steps:
      assert property ($changed(counter_value) |-> counter_value == 0
         || counter_value == $past(counter_value) + 16'h1
         || counter_value == $past(counter_value) - 16'h1)
      else $error("counter jumped");
   a_write_clears:
      assert property (s_cnt_wr |-> ##[1:4] counter_value == 0)
      else $error("counter not cleared by write");
   a_debug_freezes:
      assert property (s_frozen |=> $stable(counter_value))
      else $error("counter moved in debug");
   a_awready_pulse:
      assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held");
   a_read_answers:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   a_rvalid_holds:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped");
   a_bvalid_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
endmodule : tpcc_core_properties
bind tpcc_core tpcc_core_properties #(.WIDTH(WIDTH)) u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .debug_active(debug_active), .overflow_irq(overflow_irq),
   .counter_value(counter_value), .center_align_select(center_align_select));
`default_nettype wire

// ---- verilog/tpcc_core.sv ----
// Timer prescale counter core: AXI4-Lite registers and overflow flag
// Operation
// - Up mode flags overflow on rollover to zero
// - Center mode flags overflow turning down
// - Clear flag by read-set then write zero
// - New overflow restarts the clear sequence
// - Write one ignored; reset clears control bits
// - Enabled flag raises interrupt request
// - Center select makes counter count up/down
// - Otherwise channels follow own mode bits
// - Clock source field picks none/bus/fixed/external
// - Fixed and external clocks are synchronised
// - Prescale divides by two to the code
// - Prescaler follows source selection
// - Counter byte read latches both bytes
// - Latch released by reset or counter/control writes
// - Counter low byte write clears counter
// - Either counter byte write clears counter
// - Reset clears the counter
// - Debug mode freezes counter and latch
// - At modulo wrap to zero or turn
// - Half-written modulo suppresses overflow
// - Reset loads modulo with zero
// - Modulo zero or all ones runs free
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tpcc_core
#(
   parameter int WIDTH = 16,
   parameter int DIV_WIDTH = 3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Clock sources and debug
   input wire logic fixed_system_clock,
   input wire logic external_count_clock,
   input wire logic debug_active,
   // Toward the channels
   output logic overflow_irq,
   output logic [WIDTH-1:0] counter_value,
   output logic center_align_select,
   output logic count_down
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   tpcc_pkg::tpcc_ctrl_t ctrl_r; // Control fields
   logic overflow_flag_r; // Overflow flag
   logic clear_armed_r; // Flag read while set
   logic [1:0] dbg_sync_r; // Debug input synchroniser
   logic [4:0] aw_addr_r; // Held write address
   logic aw_full_r; // Write address taken
   logic [31:0] w_data_r; // Held write data
   logic [3:0] w_strb_r; // Held write strobes
   logic w_full_r; // Write data taken
   logic [WIDTH-1:0] latch_r; // Coherent read buffer
   logic latch_hi_r; // Buffer held, low byte still to read
   logic latch_lo_r; // Buffer held, high byte still to read
   logic [WIDTH-1:0] count; // Live counter
   logic [WIDTH-1:0] modulo; // Modulo value
   logic down; // Counting down
   logic overflow; // Overflow event
   logic tick; // Prescaler output
   logic do_write; // Write commits this cycle
   logic do_read; // Read commits this cycle
   logic wr_lane0; // Lowest byte lane written
   logic freeze; // Debug freeze
   tpcc_pkg::tpcc_wr_t wr; // Writes toward the counter
   logic [7:0] sc_byte; // Status/control readback

   // Decode of a word address
   function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
      hit = (a[4:2] == r[4:2]);
   endfunction : hit

   // ------------------------------------------------------------
   // Debug synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         dbg_sync_r <= 2'h0;
      else
         dbg_sync_r <= {dbg_sync_r[0], debug_active};
   end
   assign freeze = dbg_sync_r[1];

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
   assign wr_lane0 = w_strb_r[0];

   // Take address and data in either order, answer with both
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tpcc_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_full_r & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_full_r & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r > tpcc_pkg::ADDR_MODULO_LOW + 5'h3)
                           ? tpcc_pkg::AXI_SLVERR : tpcc_pkg::AXI_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Write requests that reach the counter engine
   always_comb
   begin
      wr.data = w_data_r[7:0];
      wr.cnt_clear = do_write & wr_lane0
         & (hit(aw_addr_r, {1'b0, tpcc_pkg::ADDR_COUNTER_HIGH})
          | hit(aw_addr_r, {1'b0, tpcc_pkg::ADDR_COUNTER_LOW}));
      wr.mod_hi_we = do_write & wr_lane0
         & hit(aw_addr_r, {1'b0, tpcc_pkg::ADDR_MODULO_HIGH});
      wr.mod_lo_we = do_write & wr_lane0
         & hit(aw_addr_r, tpcc_pkg::ADDR_MODULO_LOW);
   end

   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_r <= tpcc_pkg::tpcc_ctrl_t'(tpcc_pkg::SC_RESET[6:0]);
      else if (do_write && wr_lane0
               && hit(aw_addr_r, {1'b0, tpcc_pkg::ADDR_STATUS_CONTROL}))
         ctrl_r <= tpcc_pkg::tpcc_ctrl_t'(w_data_r[6:0]);
   end

   // ------------------------------------------------------------
   // Overflow flag with read-then-write-zero clear
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         overflow_flag_r <= 1'b0;
         clear_armed_r <= 1'b0;
      end
      else if (overflow)
      begin
         overflow_flag_r <= 1'b1;
         clear_armed_r <= 1'b0;
      end
      else
      begin
         if (do_read && overflow_flag_r
             && hit(s_axi_araddr, {1'b0, tpcc_pkg::ADDR_STATUS_CONTROL}))
            clear_armed_r <= 1'b1;
         if (do_write && wr_lane0
             && hit(aw_addr_r, {1'b0, tpcc_pkg::ADDR_STATUS_CONTROL}))
         begin
            if (clear_armed_r && !w_data_r[tpcc_pkg::SC_FLAG_BIT])
               overflow_flag_r <= 1'b0;
            clear_armed_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Coherent counter read buffer
   // ------------------------------------------------------------
   assign do_read = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         latch_hi_r <= 1'b0;
         latch_lo_r <= 1'b0;
         latch_r <= tpcc_pkg::COUNTER_RESET;
      end
      else if (wr.cnt_clear || (do_write && wr_lane0
               && hit(aw_addr_r, {1'b0, tpcc_pkg::ADDR_STATUS_CONTROL})))
      begin
         latch_hi_r <= 1'b0;
         latch_lo_r <= 1'b0;
      end
      else if (do_read && !freeze)
      begin
         if (hit(s_axi_araddr, {1'b0, tpcc_pkg::ADDR_COUNTER_HIGH}))
         begin
            if (latch_lo_r)
               latch_lo_r <= 1'b0;
            else if (!latch_hi_r)
            begin
               latch_r <= count;
               latch_hi_r <= 1'b1;
            end
         end
         else if (hit(s_axi_araddr, {1'b0, tpcc_pkg::ADDR_COUNTER_LOW}))
         begin
            if (latch_hi_r)
               latch_hi_r <= 1'b0;
            else if (!latch_lo_r)
            begin
               latch_r <= count;
               latch_lo_r <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign sc_byte = {overflow_flag_r, ctrl_r};

   // One read at a time; data from the buffer when held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= tpcc_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (do_read)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tpcc_pkg::AXI_OKAY;
            unique case (s_axi_araddr[4:2])
               3'h0: s_axi_rdata <= {24'h000000, sc_byte};
               3'h1: s_axi_rdata <= {24'h000000,
                  (latch_hi_r | latch_lo_r) ? latch_r[15:8] : count[15:8]};
               3'h2: s_axi_rdata <= {24'h000000,
                  (latch_hi_r | latch_lo_r) ? latch_r[7:0] : count[7:0]};
               3'h3: s_axi_rdata <= {24'h000000, modulo[15:8]};
               3'h4: s_axi_rdata <= {24'h000000, modulo[7:0]};
               default:
               begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= tpcc_pkg::AXI_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Clock path and counter
   // ------------------------------------------------------------
   tpcc_prescaler #(.DIV_WIDTH(DIV_WIDTH)) u_prescaler
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_src(ctrl_r.clk_src),
      .div_sel(ctrl_r.div_sel),
      .freeze(freeze),
      .fixed_system_clock(fixed_system_clock),
      .external_count_clock(external_count_clock),
      .tick(tick)
   );

   tpcc_counter #(.WIDTH(WIDTH)) u_counter
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .center(ctrl_r.center),
      .wr(wr),
      .count(count),
      .modulo(modulo),
      .down(down),
      .overflow(overflow)
   );

   // ------------------------------------------------------------
   // Registered outputs toward the channels
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         overflow_irq <= 1'b0;
         counter_value <= '0;
         center_align_select <= 1'b0;
         count_down <= 1'b0;
      end
      else
      begin
         overflow_irq <= overflow_flag_r & ctrl_r.irq_en;
         counter_value <= count;
         center_align_select <= ctrl_r.center;
         count_down <= down;
      end
   end

endmodule : tpcc_core
`default_nettype wire

// ---- verilog/tpcc_counter.sv ----
// Sixteen-bit counter with modulo, up/down mode and overflow event
`timescale 1ns/1ps
`default_nettype none
module tpcc_counter
#(
   parameter int WIDTH = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic center,
   input wire tpcc_pkg::tpcc_wr_t wr,
   output logic [WIDTH-1:0] count,
   output logic [WIDTH-1:0] modulo,
   output logic down,
   output logic overflow
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [WIDTH-1:0] count_r; // Counter value
   logic [WIDTH-1:0] mod_r; // Modulo value
   logic down_r; // Counting down in center mode
   logic mod_pend_r; // One modulo byte written, other pending
   logic free_run; // Modulo disabled
   logic at_top; // Counter at its top value
   logic wrap_up; // Up-count rollover step
   logic turn_down; // Center mode leaves the top

   assign free_run = (mod_r == tpcc_pkg::MODULO_RESET)
                   | (mod_r == tpcc_pkg::MODULO_ALL_ONES);
   assign at_top = free_run ? (count_r == tpcc_pkg::MODULO_ALL_ONES)
                            : (count_r == mod_r);
   assign wrap_up = tick & ~center & at_top;
   assign turn_down = tick & center & ~down_r & at_top;

   // Counter stepping, cleared by any counter byte write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_r <= tpcc_pkg::COUNTER_RESET;
         down_r <= 1'b0;
      end
      else if (wr.cnt_clear)
      begin
         count_r <= tpcc_pkg::COUNTER_RESET;
         down_r <= 1'b0;
      end
      else if (!center)
      begin
         down_r <= 1'b0;
         if (tick)
            count_r <= at_top ? tpcc_pkg::COUNTER_RESET
                              : count_r + 1'b1;
      end
      else if (tick)
      begin
         if (turn_down)
         begin
            down_r <= 1'b1;
            count_r <= count_r - 1'b1;
         end
         else if (down_r && count_r == tpcc_pkg::COUNTER_RESET)
         begin
            down_r <= 1'b0;
            count_r <= count_r + 1'b1;
         end
         else
            count_r <= down_r ? count_r - 1'b1 : count_r + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Modulo bytes and the write guard
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mod_r <= tpcc_pkg::MODULO_RESET;
         mod_pend_r <= 1'b0;
      end
      else
      begin
         if (wr.mod_hi_we)
            mod_r[WIDTH-1:8] <= wr.data;
         if (wr.mod_lo_we)
            mod_r[7:0] <= wr.data;
         if (wr.mod_hi_we || wr.mod_lo_we)
            mod_pend_r <= ~mod_pend_r;
      end
   end

   assign count = count_r;
   assign modulo = mod_r;
   assign down = down_r;
   // Overflow event, held back while a modulo write is half done
   assign overflow = (wrap_up | turn_down) & ~mod_pend_r;

endmodule : tpcc_counter
`default_nettype wire

// ---- verilog/tpcc_pkg.sv ----
// Package of constants and types for the timer prescale counter core
package tpcc_pkg;

   // ------------------------------------------------------------
   // Register byte addresses (one aligned word each)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0; // Status/control
   localparam logic [3:0] ADDR_COUNTER_HIGH = 4'h4; // Counter high byte
   localparam logic [3:0] ADDR_COUNTER_LOW = 4'h8; // Counter low byte
   localparam logic [3:0] ADDR_MODULO_HIGH = 4'hc; // Modulo high byte
   localparam logic [4:0] ADDR_MODULO_LOW = 5'h10; // Modulo low byte

   // ------------------------------------------------------------
   // Field positions in the status/control register
   // ------------------------------------------------------------
   localparam int SC_FLAG_BIT = 7; // Overflow flag
   localparam int SC_IRQ_EN_BIT = 6; // Overflow interrupt enable
   localparam int SC_CENTER_BIT = 5; // Center-align select
   localparam int SC_SRC_LSB = 3; // Clock source field low bit
   localparam int SC_DIV_LSB = 0; // Prescale field low bit

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] COUNTER_RESET = 16'h0000; // Counter at reset
   localparam logic [15:0] MODULO_RESET = 16'h0000; // Modulo at reset
   localparam logic [15:0] MODULO_ALL_ONES = 16'hffff; // Also free running
   localparam logic [7:0] SC_RESET = 8'h00; // Control bits at reset
   localparam logic [1:0] AXI_OKAY = 2'h0; // Normal response
   localparam logic [1:0] AXI_SLVERR = 2'h2; // Unmapped address

   // ------------------------------------------------------------
   // Clock source encoding
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      TPCC_CLK_NONE = 2'h0,
      TPCC_CLK_BUS = 2'h1,
      TPCC_CLK_FIXED = 2'h2,
      TPCC_CLK_EXT = 2'h3
   } tpcc_clk_src_t;

   // Control fields held in the status/control register
   typedef struct packed
   {
      logic irq_en; // Overflow interrupt enable
      logic center; // Center-align select
      tpcc_clk_src_t clk_src; // Clock source select
      logic [2:0] div_sel; // Prescale divisor select
   } tpcc_ctrl_t;

   // Register write requests toward the counter engine
   typedef struct packed
   {
      logic cnt_clear; // Any counter byte written
      logic mod_hi_we; // Modulo high byte written
      logic mod_lo_we; // Modulo low byte written
      logic [7:0] data; // Written byte
   } tpcc_wr_t;

endpackage : tpcc_pkg

// ---- verilog/tpcc_prescaler.sv ----
// Clock source selection, synchronisers and power-of-two prescaler
`timescale 1ns/1ps
`default_nettype none
module tpcc_prescaler
#(
   parameter int DIV_WIDTH = 3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire tpcc_pkg::tpcc_clk_src_t clk_src,
   input wire logic [DIV_WIDTH-1:0] div_sel,
   input wire logic freeze,
   input wire logic fixed_system_clock,
   input wire logic external_count_clock,
   output logic tick
);

   // ------------------------------------------------------------
   // Synchronisers for the slow clocks
   // ------------------------------------------------------------
   logic [1:0] fix_sync_r; // Fixed clock sync pair
   logic [1:0] ext_sync_r; // External clock sync pair
   logic fix_prev_r; // Last synced fixed level
   logic ext_prev_r; // Last synced external level
   logic [(1<<DIV_WIDTH)-2:0] div_r; // Prescale divider
   logic src_edge; // One step of the chosen source
   logic [(1<<DIV_WIDTH)-2:0] div_mask; // Bits compared for a tick

   // Two flops per input, second stage feeds edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fix_sync_r <= 2'h0;
         ext_sync_r <= 2'h0;
         fix_prev_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         fix_sync_r <= {fix_sync_r[0], fixed_system_clock};
         ext_sync_r <= {ext_sync_r[0], external_count_clock};
         fix_prev_r <= fix_sync_r[1];
         ext_prev_r <= ext_sync_r[1];
      end
   end

   // ------------------------------------------------------------
   // Source select, then prescale
   // ------------------------------------------------------------
   always_comb
   begin
      unique case (clk_src)
         tpcc_pkg::TPCC_CLK_NONE: src_edge = 1'b0;
         tpcc_pkg::TPCC_CLK_BUS: src_edge = 1'b1;
         tpcc_pkg::TPCC_CLK_FIXED: src_edge = fix_sync_r[1] & ~fix_prev_r;
         tpcc_pkg::TPCC_CLK_EXT: src_edge = ext_sync_r[1] & ~ext_prev_r;
      endcase
      src_edge = src_edge & ~freeze;
   end

   // Mask of low divider bits that must be ones: 2^div_sel - 1
   assign div_mask = ((1<<DIV_WIDTH)-1)'((1 << div_sel) - 1);

   // Divider counts source steps; holds when no source
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_r <= '0;
      else if (src_edge)
         div_r <= div_r + 1'b1;
   end

   // Tick on every 2^div_sel source steps
   assign tick = src_edge & ((div_r & div_mask) == div_mask);

endmodule : tpcc_prescaler
`default_nettype wire
